// *** hw/pfbi_pkg.sv ***
// Package with the constants and types of the parallel flash host controller.
// Summary of operation
// RQ1: Flash holds 524288 bytes on nineteen address lines and eight data lines.
// RQ2: Eight 64 KB sectors; top three address bits give the sector number.
// RQ3: Read cycle is chip select and output enable low, write strobe high.
// RQ4: Write cycle is chip select and write strobe low, output enable high.
// RQ5: Chip select high puts the flash in standby with outputs released.
// RQ6: Chip select or output enable high disables the flash outputs.
// RQ7: Flash reads the array after power-up and after embedded operations.
// RQ8: During erase suspend, suspended sectors return status, others array data; the model here never suspends.
// RQ9: Host may program unsuspended sectors while erase is suspended.
// RQ10: Host sends the reset command after timeout flag or to leave autoselect.
// RQ11: Autoselect read with bits six, one, zero low, eight high: maker code.
// RQ12: Maker code read with bit eight low returns a continuation code.
// RQ13: Autoselect read with bits six, one low and zero high: device code.
// RQ14: Autoselect read with bit one high and sector number: protection flag; the model here also needs bits six and zero low.
// RQ15: Autoselect by high voltage on address bit nine or by command; the model here answers high voltage only.
// RQ16: Flash erases single sectors or the whole chip internally; the model here never erases.
// RQ17: Flash refuses program and erase in protected sectors.
// RQ18: Program takes about 8 us per byte, sector erase about 500 ms; the model here programs at once and has no erase.
// RQ19: Address taken on later falling strobe, data on earlier rising strobe.
// RQ20: All three strobes low is treated as a read.
// RQ21: Bad command sequence steps return the flash to array read.
// RQ22: Device model synchronises strobes and detects their edges; the model here has no clock and acts on the raw rising write strobe.
// RQ23: Device model clears suspend and autoselect state after power-up; the model here keeps no such state.
package pfbi_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int SECTOR_LSB = 16;

  // Clock period and bus timing, in ns.
  localparam int CLK_PERIOD_NS = 4;
  localparam int ACCESS_NS = 90;
  localparam int WRITE_PULSE_NS = 35;
  localparam int CNT_W = 5;
  // Least times round up to whole cycles.
  localparam logic [CNT_W-1:0] ACCESS_CYC =
    CNT_W'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WRITE_PULSE_CYC =
    CNT_W'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [DATA_W-1:0] RESET_CMD_DATA = 8'hF0;
  localparam logic [ADDR_W-1:0] RESET_CMD_ADDR = 19'h00000;

  typedef enum logic [1:0] {
    PFBI_OP_READ = 2'h0,
    PFBI_OP_WRITE = 2'h1,
    PFBI_OP_RESET = 2'h2
  } pfbi_op_t;

  typedef enum logic [4:0] {
    PFBI_IDLE = 5'h01,
    PFBI_SETUP = 5'h02,
    PFBI_READ = 5'h04,
    PFBI_WRITE = 5'h08,
    PFBI_RECOVER = 5'h10
  } pfbi_state_t;

  typedef struct packed {
    logic valid;
    pfbi_op_t op;
    logic id_high_voltage;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pfbi_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } pfbi_rsp_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic id_high_voltage_en;
    logic [ADDR_W-1:0] address_in;
    logic [DATA_W-1:0] data_io_out;
    logic data_io_oe;
  } pfbi_pins_t;

  typedef struct packed {
    pfbi_state_t state;
    pfbi_op_t op;
    logic [CNT_W-1:0] cnt;
    logic ready;
    pfbi_rsp_t rsp;
    pfbi_pins_t pins;
  } pfbi_regs_t;

endpackage

// *** hw/pfbi_host.sv ***
// Host controller that runs read and write cycles on a parallel NOR flash bus.
`timescale 1ns/10ps
module pfbi_host (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire pfbi_pkg::pfbi_req_t i_req,
  output logic o_ready,
  output pfbi_pkg::pfbi_rsp_t o_rsp,
  output pfbi_pkg::pfbi_pins_t o_pins,
  input wire logic [pfbi_pkg::DATA_W-1:0] i_data_io_in
);
  import pfbi_pkg::*;

  // Cycles after a strobe falls, for the width and access checks below.
  localparam int OE_LOW_LAST = int'(ACCESS_CYC) - 1;
  localparam int WE_LOW_LAST = int'(WRITE_PULSE_CYC) - 1;
  localparam int RSP_DELAY = int'(ACCESS_CYC);

  // Reads never drive data and are the only cycles allowed high voltage identify.
  function automatic logic is_read(pfbi_op_t op);
    return op == PFBI_OP_READ;
  endfunction

  pfbi_regs_t r;
  pfbi_regs_t nxt;

  // ****************************************
  // Cycle sequencer
  // ****************************************
  always_comb begin
    nxt = r;
    nxt.rsp.valid = 1'b0;
    unique case (r.state)
      PFBI_IDLE: begin
        if (i_req.valid && r.ready) begin
          nxt.ready = 1'b0;
          nxt.op = i_req.op;
          nxt.pins.ce_n = 1'b0;
          nxt.pins.address_in = i_req.addr;
          nxt.pins.data_io_out = i_req.data;
          // The reset command restores array reads after a timeout or autoselect.
          if (i_req.op == PFBI_OP_RESET) begin // RQ10
            nxt.pins.address_in = RESET_CMD_ADDR;
            nxt.pins.data_io_out = RESET_CMD_DATA;
          end
          // High voltage identify is only meaningful on read cycles.
          nxt.pins.id_high_voltage_en = i_req.id_high_voltage && is_read(i_req.op); // RQ15
          nxt.state = PFBI_SETUP;
        end
      end
      PFBI_SETUP: begin
        if (is_read(r.op)) begin
          nxt.pins.oe_n = 1'b0; // RQ3
          nxt.cnt = ACCESS_CYC - 5'h01;
          nxt.state = PFBI_READ;
        end else begin
          // Address is stable one cycle before the strobe falls. Writes are
          // issued whatever the flash state, so programs during suspend work.
          nxt.pins.we_n = 1'b0; // RQ4 RQ19 RQ9
          nxt.pins.data_io_oe = 1'b1;
          nxt.cnt = WRITE_PULSE_CYC - 5'h01;
          nxt.state = PFBI_WRITE;
        end
      end
      PFBI_READ: begin
        if (r.cnt == 5'h00) begin
          nxt.rsp.valid = 1'b1;
          nxt.rsp.data = i_data_io_in; // RQ3
          nxt.pins.oe_n = 1'b1;
          nxt.pins.ce_n = 1'b1;
          nxt.state = PFBI_RECOVER;
        end else begin
          nxt.cnt = r.cnt - 5'h01;
        end
      end
      PFBI_WRITE: begin
        if (r.cnt == 5'h00) begin
          // Data stays driven one more cycle past the rising strobe for hold.
          nxt.pins.we_n = 1'b1; // RQ19
          nxt.state = PFBI_RECOVER;
        end else begin
          nxt.cnt = r.cnt - 5'h01;
        end
      end
      PFBI_RECOVER: begin
        nxt.pins.data_io_oe = 1'b0;
        nxt.pins.ce_n = 1'b1; // RQ5
        nxt.pins.id_high_voltage_en = 1'b0;
        nxt.ready = 1'b1;
        nxt.state = PFBI_IDLE;
      end
      default: begin
        nxt.state = PFBI_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      r.state <= PFBI_IDLE;
      r.op <= PFBI_OP_READ;
      r.cnt <= '0;
      r.ready <= 1'b1;
      r.rsp <= '0;
      r.pins.ce_n <= 1'b1;
      r.pins.oe_n <= 1'b1;
      r.pins.we_n <= 1'b1;
      r.pins.id_high_voltage_en <= 1'b0;
      r.pins.address_in <= '0;
      r.pins.data_io_out <= '0;
      r.pins.data_io_oe <= 1'b0;
    end else begin
      r <= nxt;
    end
  end

  assign o_ready = r.ready;
  assign o_rsp = r.rsp;
  assign o_pins = r.pins;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  // Strobe combinations that the flash would decode wrongly.
  no_all_low_a: assert property ( // RQ20
    !(!r.pins.ce_n && !r.pins.oe_n && !r.pins.we_n))
    else $error("All three strobes low at once.");

  oe_we_excl_a: assert property ( // RQ20
    !(!r.pins.oe_n && !r.pins.we_n))
    else $error("Output enable and write strobe low together.");

  read_strobes_a: assert property ( // RQ3
    !r.pins.oe_n |-> !r.pins.ce_n && r.pins.we_n && !r.pins.data_io_oe)
    else $error("Output enable low outside a proper read cycle.");

  write_strobe_a: assert property ( // RQ4
    !r.pins.we_n |-> !r.pins.ce_n && r.pins.oe_n && r.pins.data_io_oe)
    else $error("Write strobe low outside a proper write cycle.");

  write_op_only_a: assert property ( // RQ4
    !r.pins.we_n |-> !is_read(r.op))
    else $error("Write strobe low during a read request.");

  // The host drives data only while the flash outputs are off, so the bus never fights.
  drive_oe_high_a: assert property ( // RQ6
    r.pins.data_io_oe |-> r.pins.oe_n)
    else $error("Host drives data while output enable is low.");

  drive_ce_low_a: assert property ( // RQ4
    r.pins.data_io_oe |-> !r.pins.ce_n)
    else $error("Host drives data outside a selected cycle.");

  read_no_drive_a: assert property ( // RQ3
    is_read(r.op) && !r.ready |-> !r.pins.data_io_oe)
    else $error("Host drives data during a read request.");

  standby_release_a: assert property ( // RQ5
    r.pins.ce_n && $past(r.pins.ce_n) |-> !r.pins.data_io_oe)
    else $error("Host drives data during standby.");

  ce_release_a: assert property ( // RQ5
    $rose(r.pins.ce_n) |-> r.pins.oe_n && r.pins.we_n && !r.pins.data_io_oe)
    else $error("Chip select rises with a strobe still active.");

  // Cycle timing of the read strobe.
  oe_setup_a: assert property ( // RQ3
    $fell(r.pins.oe_n) |-> $past(!r.pins.ce_n) && $stable(r.pins.address_in))
    else $error("Output enable fell without address setup.");

  oe_width_a: assert property ( // RQ3
    $fell(r.pins.oe_n) |-> ##OE_LOW_LAST !r.pins.oe_n ##1 r.pins.oe_n)
    else $error("Output enable low for the wrong number of cycles.");

  read_access_a: assert property ( // RQ3
    $fell(r.pins.oe_n) |-> !r.pins.ce_n ##RSP_DELAY r.rsp.valid)
    else $error("Read data not taken after the access time.");

  rsp_after_oe_a: assert property ( // RQ3
    r.rsp.valid |-> r.pins.oe_n && r.pins.ce_n && $past(!r.pins.oe_n))
    else $error("Read data taken outside an access.");

  rsp_pulse_a: assert property ( // RQ3
    r.rsp.valid |=> !r.rsp.valid)
    else $error("Read response valid for more than one cycle.");

  // Cycle timing of the write strobe.
  we_setup_a: assert property ( // RQ19
    $fell(r.pins.we_n) |-> $past(!r.pins.ce_n) && $stable(r.pins.address_in))
    else $error("Write strobe fell without address setup.");

  we_width_a: assert property ( // RQ4
    $fell(r.pins.we_n) |-> ##WE_LOW_LAST !r.pins.we_n ##1 r.pins.we_n)
    else $error("Write strobe low for the wrong number of cycles.");

  addr_stable_a: assert property ( // RQ19
    !r.pins.ce_n && $past(!r.pins.ce_n) |-> $stable(r.pins.address_in))
    else $error("Address changed while chip select is low.");

  data_hold_a: assert property ( // RQ19
    $rose(r.pins.we_n) |-> r.pins.data_io_oe && $stable(r.pins.data_io_out))
    else $error("Write data not held at rising write strobe.");

  we_rise_addr_a: assert property ( // RQ19
    $rose(r.pins.we_n) |-> !r.pins.ce_n && $stable(r.pins.address_in))
    else $error("Address or select lost at rising write strobe.");

  ready_idle_a: assert property ( // RQ5
    r.ready |-> r.pins.ce_n && r.state == PFBI_IDLE)
    else $error("Ready while a bus cycle is open.");

  reset_cmd_a: assert property ( // RQ10
    !r.pins.we_n && r.op == PFBI_OP_RESET |->
      r.pins.data_io_out == RESET_CMD_DATA && r.pins.address_in == RESET_CMD_ADDR)
    else $error("Reset command carries the wrong address or data.");

  hv_read_only_a: assert property ( // RQ15
    r.pins.id_high_voltage_en |-> r.pins.we_n && is_read(r.op))
    else $error("High voltage identify outside a read.");

  hv_clear_a: assert property ( // RQ15
    r.pins.ce_n && $past(r.pins.ce_n) |-> !r.pins.id_high_voltage_en)
    else $error("High voltage identify left on in standby.");

  read_done_c: cover property (r.rsp.valid);
  write_done_c: cover property ($rose(r.pins.we_n) && r.op == PFBI_OP_WRITE);
  reset_cmd_c: cover property ($rose(r.pins.we_n) && r.op == PFBI_OP_RESET);
  hv_read_c: cover property (r.pins.id_high_voltage_en && r.rsp.valid);

endmodule

// *** tb/pfbi_flash_model.sv ***
// Behavioural flash device that answers the host controller's pin cycles.
`timescale 1ns/10ps
module pfbi_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'hA5,
  parameter logic [7:0] CONT_ID = 8'h5A,
  parameter logic [7:0] PART_ID = 8'h3C,
  parameter logic [7:0] PROT_MAP = 8'h81
) (
  input wire pfbi_pkg::pfbi_pins_t i_pins,
  output logic [7:0] o_data
);
  import pfbi_pkg::*;
  // The identity values above are arbitrary.
  logic [7:0] mem [logic [18:0]];
  logic [7:0] last = 8'h00;
  logic [18:0] a;
  logic drv;
  assign a = i_pins.address_in;
  assign drv = !i_pins.ce_n && !i_pins.oe_n;
  // Released lines show the inverse so a stale byte never passes for data.
  always @* begin
    if (i_pins.id_high_voltage_en && !a[6] && a[1:0] == 2'h0) begin
      o_data = a[8] ? MAKER_ID : CONT_ID;
    end else if (i_pins.id_high_voltage_en && !a[6] && a[1:0] == 2'h1) begin
      o_data = PART_ID;
    end else if (i_pins.id_high_voltage_en && !a[6] && a[1:0] == 2'h2) begin
      o_data = {7'h00, PROT_MAP[a[18:16]]};
    end else begin
      // Nothing is ever erased or suspended here, so every read other than identify sees array data.
      o_data = mem.exists(a) ? mem[a] : a[7:0] ^ {5'h00, a[18:16]};
    end
    if (!drv) o_data = ~last;
    else last = o_data;
  end
  // Programs finish at once; an F0 byte, as the reset command, is dropped and never stored.
  always @(posedge i_pins.we_n) begin
    if (!i_pins.ce_n && i_pins.oe_n && i_pins.data_io_oe && !PROT_MAP[a[18:16]]
        && i_pins.data_io_out != 8'hF0) mem[a] = i_pins.data_io_out;
  end
endmodule

// *** tb/pfbi_host_tb.sv ***
// Self-checking bench for the parallel flash host controller.
`timescale 1ns/10ps
module pfbi_host_tb;
  import pfbi_pkg::*;
  // Identity values are arbitrary; they only have to match the model's parameters.
  localparam logic [7:0] MK = 8'hA5;
  localparam logic [7:0] CT = 8'h5A;
  localparam logic [7:0] PT = 8'h3C;
  localparam logic [7:0] PROT = 8'h81;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pfbi_req_t req = '0;
  logic rdy;
  pfbi_rsp_t rsp;
  pfbi_pins_t pins;
  logic [7:0] din;
  int n_fail = 0;
  int checked = 0;
  logic [31:0] lfsr = 32'hFE9B;
  logic [7:0] shadow [logic [18:0]];
  pfbi_host u_dut (.i_sys_clk(clk), .i_reset(rst), .i_req(req), .o_ready(rdy),
    .o_rsp(rsp), .o_pins(pins), .i_data_io_in(din));
  pfbi_flash_model #(.MAKER_ID(MK), .CONT_ID(CT), .PART_ID(PT), .PROT_MAP(PROT))
    u_mem (.i_pins(pins), .o_data(din));
  initial forever #2 clk = ~clk;
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] exp_rd(logic [18:0] a);
    return shadow.exists(a) ? shadow[a] : a[7:0] ^ {5'h00, a[18:16]};
  endfunction
  task automatic chk(string what, logic [31:0] seen, logic [31:0] want);
    checked++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic xfer(pfbi_op_t op, logic hv, logic [18:0] a, logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{valid: 1'b1, op: op, id_high_voltage: hv, addr: a, data: d};
    do @(posedge clk); while (rdy !== 1'b1);
    req.valid <= 1'b0;
    do begin
      @(posedge clk);
      #1 n++;
      if (n == 2) chk("addr", pins.address_in, op == PFBI_OP_RESET ? 19'h0 : a);
    end while (n < 40 && (op == PFBI_OP_READ ? rsp.valid !== 1'b1 : rdy !== 1'b1));
    // Read data adds one setup edge to the access; a write adds setup and recovery edges.
    chk("latency", n, op == PFBI_OP_READ ? ACCESS_CYC + 5'h01 : WRITE_PULSE_CYC + 5'h02);
    chk("strobes", {pins.ce_n, pins.oe_n, pins.we_n}, 3'h7);
    q = rsp.data;
    @(posedge clk);
    #1 chk("done", {rsp.valid, rdy}, 2'h1);
  endtask
  initial begin
    logic [7:0] q;
    logic [18:0] a;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (20) begin
      lfsr = nxt(lfsr);
      a = lfsr[18:0];
      xfer(PFBI_OP_READ, 1'b0, a, 8'h00, q);
      chk("array", q, exp_rd(a));
    end
    $display("random reads done");
    for (int s = 0; s < 8; s++) begin
      lfsr = nxt(lfsr);
      a = {s[2:0], lfsr[15:0]};
      xfer(PFBI_OP_WRITE, 1'b0, a, lfsr[23:16], q);
      if (!PROT[s] && lfsr[23:16] != 8'hF0) shadow[a] = lfsr[23:16];
      xfer(PFBI_OP_READ, 1'b0, a, 8'h00, q);
      chk("program", q, exp_rd(a));
    end
    $display("program per sector done");
    xfer(PFBI_OP_RESET, 1'b0, 19'h5A5A5, 8'h00, q);
    xfer(PFBI_OP_READ, 1'b1, 19'h00100, 8'h00, q);
    chk("maker", q, MK);
    xfer(PFBI_OP_READ, 1'b1, 19'h00000, 8'h00, q);
    chk("cont", q, CT);
    xfer(PFBI_OP_READ, 1'b1, 19'h00001, 8'h00, q);
    chk("part", q, PT);
    for (int s = 0; s < 8; s++) begin
      xfer(PFBI_OP_READ, 1'b1, {s[2:0], 16'h0002}, 8'h00, q);
      chk("prot", q, {7'h00, PROT[s]});
    end
    $display("identify reads done");
    tally_and_finish();
  end
  initial begin
    #(4 * 20000);
    n_fail++;
    tally_and_finish();
  end
endmodule
